/* verilog/monitor_status_flags.sv */
`timescale 1ns/100ps
module monitor_status_flags #(
    parameter bit LATCH_VARIANT = 1'b1,
    parameter int STEP_CYCLES = status_flags_pkg::TIMER_STEP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [status_flags_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Measurement and limit inputs
    input wire status_flags_pkg::monitor_in_s mon,
    input wire logic shutdown_signal,
    // Shared pin output side
    output logic gpio_out,
    output logic gpio_oe
);
    import status_flags_pkg::*;

    main_state_s s_reg, s_next;
    logic [4:0] ch_hit;
    logic [3:0] fan_hit;
    logic over_hit;
    logic near_hit;
    logic [7:0] ev1;
    logic [7:0] ev2;
    logic [7:0] still2;
    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [7:0] view1;
    logic [7:0] view2;
    logic [7:0] sum_mask;
    logic [7:0] idx;
    logic accept;
    logic rd_acc;
    logic wr_acc;
    logic clr1;
    logic clr2;
    logic restart;
    logic timer_over;
    logic summary;

    // Bus handshake: a request answers one cycle after it is seen
    assign idx = address[ADDR_W-1:2];
    assign accept = !s_reg.wait_req;
    assign rd_acc = read && accept;
    assign wr_acc = write && accept;
    assign clr1 = rd_acc && (idx == IDX_STATUS_ONE);
    assign clr2 = rd_acc && (idx == IDX_STATUS_TWO);

    // Limit comparisons
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            ch_hit[i] = limit_hit(mon.reading[i], mon.low_limit[i], mon.high_limit[i]);
        end
        for (int i = 0; i < 4; i++) begin
            fan_hit[i] = fan_slow(mon.fan_period[i], mon.fan_minimum[i]);
        end
        over_hit = 1'b0;
        near_hit = 1'b0;
        for (int i = 0; i < 3; i++) begin
            over_hit = over_hit | (mon.reading[CH_REMOTE_ONE + i] > mon.shutdown_limit[i]);
            near_hit = near_hit | above_release(mon.reading[CH_REMOTE_ONE + i], mon.shutdown_limit[i],
                mon.hysteresis[i]);
        end
    end

    // Status one events
    always_comb begin
        ev1 = STATUS_RESET;
        ev1[BIT_CORE] = ch_hit[CH_CORE];
        ev1[BIT_SUPPLY] = ch_hit[CH_SUPPLY];
        ev1[BIT_REMOTE_ONE] = ch_hit[CH_REMOTE_ONE];
        ev1[BIT_LOCAL] = ch_hit[CH_LOCAL];
        ev1[BIT_REMOTE_TWO] = ch_hit[CH_REMOTE_TWO];
    end

    // Status two events and present conditions
    always_comb begin
        ev2 = STATUS_RESET;
        ev2[BIT_LATCH] = LATCH_VARIANT && mon.remote_two_latch;
        ev2[BIT_OVERTEMP] = over_hit;
        for (int i = 0; i < 3; i++) begin
            ev2[BIT_FAN_FIRST + i] = fan_hit[i] && mon.fan_drive_on[i];
        end
        case (s_reg.pin_mode)
            PIN_FAN4: ev2[BIT_SHARED] = fan_hit[3] && mon.fan_drive_on[2];
            PIN_TIMER: ev2[BIT_SHARED] = timer_over;
            default: ev2[BIT_SHARED] = 1'b0;
        endcase
        ev2[BIT_DIODE1] = mon.diode_fault[0];
        ev2[BIT_DIODE2] = mon.diode_fault[1];
        still2 = ev2;
        still2[BIT_OVERTEMP] = near_hit;
        // Timer flag clears on a status two read; the count restarts with it
        if (s_reg.pin_mode == PIN_TIMER) begin
            still2[BIT_SHARED] = 1'b0;
        end
    end

    assign restart = (s_reg.pin_mode != PIN_TIMER) || clr2;

    sticky_flags u_flags_one (
        .sys_clk(sys_clk),
        .rst(rst),
        .event_hit(ev1),
        .still_hit(ev1),
        .rd_clear(clr1),
        .flags(flags1)
    );

    sticky_flags u_flags_two (
        .sys_clk(sys_clk),
        .rst(rst),
        .event_hit(ev2),
        .still_hit(still2),
        .rd_clear(clr2),
        .flags(flags2)
    );

    shutdown_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .active(shutdown_signal),
        .restart(restart),
        .limit(s_reg.timer_limit),
        .over(timer_over)
    );

    // Register views
    always_comb begin
        view2 = flags2;
        sum_mask = 8'hFF;
        if (s_reg.pin_mode == PIN_GPIO) begin
            view2[BIT_SHARED] = s_reg.gpio;
            sum_mask[BIT_SHARED] = 1'b0;
        end
        summary = |(flags2 & sum_mask);
        view1 = flags1 & STATUS_ONE_USED;
        view1[BIT_SUMMARY] = summary;
    end

    // Register file and handshake
    always_comb begin
        s_next = s_reg;
        s_next.wait_req = 1'b1;
        if ((read || write) && s_reg.wait_req) begin
            s_next.wait_req = 1'b0;
            s_next.rdata = 32'h0000_0000;
            if (read) begin
                case (idx)
                    IDX_STATUS_ONE: s_next.rdata[7:0] = view1;
                    IDX_STATUS_TWO: s_next.rdata[7:0] = view2;
                    IDX_PIN_CTRL: s_next.rdata[1:0] = s_reg.pin_mode;
                    IDX_TIMER_LIMIT: s_next.rdata[7:0] = s_reg.timer_limit;
                    default: s_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (wr_acc && byteenable[0]) begin
            case (idx)
                IDX_STATUS_TWO: begin
                    if (s_reg.pin_mode == PIN_GPIO) begin
                        s_next.gpio = writedata[BIT_SHARED];
                    end
                end
                IDX_PIN_CTRL: begin
                    case (writedata[1:0])
                        2'b01: s_next.pin_mode = PIN_GPIO;
                        2'b10: s_next.pin_mode = PIN_TIMER;
                        default: s_next.pin_mode = PIN_FAN4;
                    endcase
                end
                IDX_TIMER_LIMIT: s_next.timer_limit = writedata[7:0];
                default: s_next.gpio = s_reg.gpio;
            endcase
        end
        s_next.gpio_oe = (s_next.pin_mode == PIN_GPIO);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= MAIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign readdata = s_reg.rdata;
    assign waitrequest = s_reg.wait_req;
    assign gpio_out = s_reg.gpio;
    assign gpio_oe = s_reg.gpio_oe;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_wait_answer;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("request not answered in one cycle");

    property p_wait_single;
        !waitrequest |=> waitrequest;
    endproperty
    a_wait_single: assert property (p_wait_single) else $error("waitrequest low for two cycles");

    property p_core_high;
        mon.reading[CH_CORE] > mon.high_limit[CH_CORE] |=> flags1[BIT_CORE];
    endproperty
    a_core_high: assert property (p_core_high) else $error("core high event not flagged");

    property p_supply_low;
        mon.reading[CH_SUPPLY] == mon.low_limit[CH_SUPPLY] |=> flags1[BIT_SUPPLY];
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("supply at low limit not flagged");

    property p_local_temp;
        ch_hit[CH_LOCAL] |=> flags1[BIT_LOCAL];
    endproperty
    a_local_temp: assert property (p_local_temp) else $error("local temperature not flagged");

    property p_summary;
        clr1 |-> readdata[BIT_SUMMARY] == $past(summary);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    property p_reserved;
        clr1 |-> readdata[0] == 1'b0 && readdata[3] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit read as one");

    property p_reset_zero;
        $past(rst) |-> flags1 == STATUS_RESET && flags2 == STATUS_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");

    property p_latch;
        LATCH_VARIANT && mon.remote_two_latch |=> flags2[BIT_LATCH];
    endproperty
    a_latch: assert property (p_latch) else $error("latch flag not set");

    property p_overtemp;
        over_hit |=> flags2[BIT_OVERTEMP];
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("shutdown limit not flagged");

    property p_fan_gate;
        !mon.fan_drive_on[2] && !flags2[BIT_FAN_FIRST + 2] |=> !flags2[BIT_FAN_FIRST + 2];
    endproperty
    a_fan_gate: assert property (p_fan_gate) else $error("fan flag set with drive off");

    property p_fan4;
        s_reg.pin_mode == PIN_FAN4 && fan_hit[3] && mon.fan_drive_on[2] |=> flags2[BIT_SHARED];
    endproperty
    a_fan4: assert property (p_fan4) else $error("fan four not flagged");

    property p_gpio;
        wr_acc && byteenable[0] && idx == IDX_STATUS_TWO && s_reg.pin_mode == PIN_GPIO
            |=> gpio_out == $past(writedata[BIT_SHARED]);
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin level not written");

    property p_diode;
        mon.diode_fault[1] |=> flags2[BIT_DIODE2];
    endproperty
    a_diode: assert property (p_diode) else $error("diode two fault not flagged");

    c_read_one: cover property (clr1 && readdata[BIT_SUMMARY]);
    c_gpio_write: cover property (wr_acc && idx == IDX_STATUS_TWO && s_reg.pin_mode == PIN_GPIO);
    c_fan4: cover property (s_reg.pin_mode == PIN_FAN4 && ev2[BIT_SHARED]);
endmodule

/* inc/status_flags_pkg.sv */
package status_flags_pkg;
    localparam int ADDR_W = 10;
    localparam int REG_W = 8;
    localparam logic [7:0] IDX_STATUS_ONE = 8'h41;
    localparam logic [7:0] IDX_STATUS_TWO = 8'h42;
    localparam logic [7:0] IDX_PIN_CTRL = 8'h43;
    localparam logic [7:0] IDX_TIMER_LIMIT = 8'h7A;
    // Channel order in the reading and limit arrays
    localparam int CH_CORE = 0;
    localparam int CH_SUPPLY = 1;
    localparam int CH_REMOTE_ONE = 2;
    localparam int CH_LOCAL = 3;
    localparam int CH_REMOTE_TWO = 4;
    // Status one fields
    localparam int BIT_CORE = 1;
    localparam int BIT_SUPPLY = 2;
    localparam int BIT_REMOTE_ONE = 4;
    localparam int BIT_LOCAL = 5;
    localparam int BIT_REMOTE_TWO = 6;
    localparam int BIT_SUMMARY = 7;
    localparam logic [7:0] STATUS_ONE_USED = 8'h76;
    // Status two fields
    localparam int BIT_LATCH = 0;
    localparam int BIT_OVERTEMP = 1;
    localparam int BIT_FAN_FIRST = 2;
    localparam int BIT_SHARED = 5;
    localparam int BIT_DIODE1 = 6;
    localparam int BIT_DIODE2 = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] TIMER_LIMIT_RESET = 8'h00;
    localparam logic [15:0] TACH_LIMIT_OFF_LO = 16'h0000;
    localparam logic [15:0] TACH_LIMIT_OFF_HI = 16'hFFFF;
    // Timer step: one limit count per step of assertion time
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMER_STEP_NS = 1000;
    localparam int TIMER_STEP_CYCLES = (TIMER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PIN_FAN4 = 2'b00,
        PIN_GPIO = 2'b01,
        PIN_TIMER = 2'b10
    } pin_mode_e;

    typedef struct packed {
        logic [4:0][7:0] reading;
        logic [4:0][7:0] low_limit;
        logic [4:0][7:0] high_limit;
        logic [2:0][7:0] shutdown_limit;
        logic [2:0][7:0] hysteresis;
        logic [3:0][15:0] fan_period;
        logic [3:0][15:0] fan_minimum;
        logic [2:0] fan_drive_on;
        logic [1:0] diode_fault;
        logic remote_two_latch;
    } monitor_in_s;

    typedef struct packed {
        logic wait_req;
        logic [31:0] rdata;
        pin_mode_e pin_mode;
        logic [7:0] timer_limit;
        logic gpio;
        logic gpio_oe;
    } main_state_s;

    typedef struct packed {
        logic [REG_W-1:0] flags;
    } flag_state_s;

    typedef struct packed {
        logic [15:0] pre;
        logic [8:0] acc;
        logic over;
    } timer_state_s;

    localparam main_state_s MAIN_RESET = '{wait_req: 1'b1, rdata: 32'h0000_0000, pin_mode: PIN_FAN4,
        timer_limit: TIMER_LIMIT_RESET, gpio: 1'b0, gpio_oe: 1'b0};
    localparam flag_state_s FLAG_RESET = '{flags: STATUS_RESET};
    localparam timer_state_s TIMER_RESET = '{pre: 16'h0000, acc: 9'h000, over: 1'b0};

    function automatic logic limit_hit(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        limit_hit = (v > hi) || (v <= lo);
    endfunction

    function automatic logic fan_slow(input logic [15:0] period, input logic [15:0] minimum);
        fan_slow = (minimum != TACH_LIMIT_OFF_LO) && (minimum != TACH_LIMIT_OFF_HI) && (period > minimum);
    endfunction

    function automatic logic above_release(input logic [7:0] t, input logic [7:0] lim, input logic [7:0] hyst);
        above_release = (lim > hyst) ? (t >= lim - hyst) : 1'b1;
    endfunction
endpackage

/* verilog/sticky_flags.sv */
`timescale 1ns/100ps
module sticky_flags (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Conditions
    input wire logic [status_flags_pkg::REG_W-1:0] event_hit,
    input wire logic [status_flags_pkg::REG_W-1:0] still_hit,
    input wire logic rd_clear,
    // Held flags
    output logic [status_flags_pkg::REG_W-1:0] flags
);
    import status_flags_pkg::*;
    flag_state_s s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        // Set wins over a clearing read
        if (rd_clear) begin
            s_next.flags = (s_reg.flags & still_hit) | event_hit;
        end else begin
            s_next.flags = s_reg.flags | event_hit;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= FLAG_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign flags = s_reg.flags;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_set_wins;
        rd_clear && event_hit[1] |=> flags[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost under clearing read");

    property p_clear_gone;
        rd_clear && !still_hit[2] && !event_hit[2] |=> !flags[2];
    endproperty
    a_clear_gone: assert property (p_clear_gone) else $error("flag kept after read with condition gone");

    property p_hold_present;
        flags[4] && rd_clear && still_hit[4] |=> flags[4] [*1];
    endproperty
    a_hold_present: assert property (p_hold_present) else $error("flag cleared while condition present");
endmodule

/* verilog/shutdown_timer.sv */
`timescale 1ns/100ps
module shutdown_timer #(
    parameter int STEP_CYCLES = status_flags_pkg::TIMER_STEP_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic active,
    input wire logic restart,
    input wire logic [7:0] limit,
    // Result
    output logic over
);
    import status_flags_pkg::*;
    localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
    timer_state_s s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (restart) begin
            s_next = TIMER_RESET;
        end else if (active) begin
            if (s_reg.pre >= STEP_LAST) begin
                s_next.pre = 16'h0000;
                if (s_reg.acc != 9'h1FF) begin
                    s_next.acc = s_reg.acc + 9'h001;
                end
            end else begin
                s_next.pre = s_reg.pre + 16'h0001;
            end
        end
        s_next.over = !restart && (s_next.acc > {1'b0, limit});
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= TIMER_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign over = s_reg.over;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_restart;
        restart |=> !over && s_reg.acc == 9'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not cleared by restart");

    property p_over_value;
        $stable(limit) && !$past(restart) |-> over == (s_reg.acc > {1'b0, limit});
    endproperty
    a_over_value: assert property (p_over_value) else $error("timer flag disagrees with count");

    c_timer_over: cover property (!over ##1 over);
endmodule

/* test/test_monitor_status_flags.sv */
`timescale 1ns/100ps
module test_monitor_status_flags;
    import status_flags_pkg::*;
    logic sys_clk;
    logic rst;
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    monitor_in_s mon;
    logic shutdown_signal;
    logic gpio_out;
    logic gpio_oe;
    logic [7:0] notes[$];
    int failures;
    int n_compared;
    // Flag of each event source: 0-4 channels, 5 latch, 6 overtemp, 7-10 fans, 11-12 diodes
    logic [7:0] src_bit [13] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40, 8'h01, 8'h02,
        8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

    monitor_status_flags #(.LATCH_VARIANT(1'b1), .STEP_CYCLES(2)) uut (
        .sys_clk(sys_clk),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .mon(mon),
        .shutdown_signal(shutdown_signal),
        .gpio_out(gpio_out),
        .gpio_oe(gpio_oe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        n_compared++;
        if (seen !== expv) begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask

    // Answers are taken at the edge that samples waitrequest low
    always @(posedge sys_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                failures++;
                $display("MISMATCH at %0t: read answer without expectation", $time);
            end else begin
                check(readdata[7:0], notes.pop_front());
            end
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Hold the request until the edge that samples waitrequest low
    task automatic wait_ack();
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 100);
        if (waitrequest !== 1'b0) begin
            failures++;
            $display("MISMATCH at %0t: no bus answer", $time);
            complete_run();
        end
    endtask

    task automatic bus_read(input logic [7:0] idx, input logic [7:0] expv);
        notes.push_back(expv);
        @(posedge sys_clk);
        address <= {idx, 2'b00};
        read <= 1'b1;
        wait_ack();
        read <= 1'b0;
    endtask

    task automatic bus_write(input logic [7:0] idx, input logic [7:0] data, input logic [3:0] be);
        logic [31:0] r;
        r = $urandom();
        @(posedge sys_clk);
        address <= {idx, 2'b00};
        writedata <= {r[31:8], data};
        byteenable <= be;
        write <= 1'b1;
        wait_ack();
        write <= 1'b0;
    endtask

    // In-range reading, below every release level
    function automatic logic [7:0] rnd_ok();
        return 8'h11 + 8'($urandom_range(0, 8'h9E));
    endfunction

    task automatic set_src(input int id, input bit on);
        @(posedge sys_clk);
        if (id < 5) mon.reading[id] <= on ? ((id % 2) ? 8'hF1 : 8'h10) : rnd_ok();
        else if (id == 5) mon.remote_two_latch <= on;
        else if (id == 6) mon.reading[CH_REMOTE_TWO] <= on ? 8'hC1 : rnd_ok();
        else if (id < 11) mon.fan_period[id-7] <= on ? 16'h1001 : 16'h1000;
        else mon.diode_fault[id-11] <= on;
    endtask

    task automatic pulse(input int n);
        @(posedge sys_clk);
        shutdown_signal <= 1'b1;
        repeat (n) @(posedge sys_clk);
        shutdown_signal <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        shutdown_signal = 1'b0;
        mon = '0;
        mon.reading = {5{8'h80}};
        mon.low_limit = {5{8'h10}};
        mon.high_limit = {5{8'hF0}};
        mon.shutdown_limit = {8'hC0, 8'hFF, 8'hFF};
        mon.hysteresis = {3{8'h10}};
        mon.fan_period = {4{16'h1000}};
        mon.fan_minimum = {4{16'h1000}};
        mon.fan_drive_on = 3'b111;
        failures = 0;
        n_compared = 0;
        void'($urandom(32'h86E3));
        idle(2);
        rst <= 1'b0;
        bus_read(IDX_STATUS_ONE, 8'h00);
        bus_read(IDX_STATUS_TWO, 8'h00);
        for (int id = 0; id < 13; id++) begin
            logic [7:0] r;
            r = (id < 5) ? IDX_STATUS_ONE : IDX_STATUS_TWO;
            set_src(id, 1'b1);
            idle(2);
            bus_read(r, src_bit[id]);
            if (id >= 5) bus_read(IDX_STATUS_ONE, 8'h80);
            bus_read(r, src_bit[id]);
            set_src(id, 1'b0);
            idle(2);
            bus_read(r, src_bit[id]);
            bus_read(r, 8'h00);
        end
        // Release only below limit minus hysteresis
        set_src(6, 1'b1);
        idle(2);
        bus_read(IDX_STATUS_TWO, 8'h02);
        @(posedge sys_clk);
        mon.reading[CH_REMOTE_TWO] <= 8'hB0;
        idle(2);
        bus_read(IDX_STATUS_TWO, 8'h02);
        bus_read(IDX_STATUS_TWO, 8'h02);
        set_src(6, 1'b0);
        idle(2);
        bus_read(IDX_STATUS_TWO, 8'h02);
        bus_read(IDX_STATUS_TWO, 8'h00);
        // Slow fans with third drive off, then disabled minimum
        @(posedge sys_clk);
        mon.fan_drive_on <= 3'b011;
        mon.fan_period <= {4{16'hFFFF}};
        idle(2);
        bus_read(IDX_STATUS_TWO, 8'h0C);
        @(posedge sys_clk);
        mon.fan_drive_on <= 3'b111;
        mon.fan_minimum <= {4{16'hFFFF}};
        idle(2);
        bus_read(IDX_STATUS_TWO, 8'h0C);
        bus_read(IDX_STATUS_TWO, 8'h00);
        @(posedge sys_clk);
        mon.fan_period <= {4{16'h1000}};
        mon.fan_minimum <= {4{16'h1000}};
        // Read-only, unmapped and fan-mode writes change nothing
        bus_write(IDX_STATUS_ONE, 8'hFF, 4'h1);
        bus_read(IDX_STATUS_ONE, 8'h00);
        bus_write(8'h10, 8'hFF, 4'h1);
        bus_read(8'h10, 8'h00);
        bus_write(IDX_STATUS_TWO, 8'hFF, 4'h1);
        bus_read(IDX_STATUS_TWO, 8'h00);
        // Shared pin as output
        bus_write(IDX_PIN_CTRL, 8'h01, 4'h1);
        bus_write(IDX_STATUS_TWO, 8'h20, 4'h1);
        idle(1);
        @(negedge sys_clk);
        check({7'h00, gpio_oe}, 8'h01);
        check({7'h00, gpio_out}, 8'h01);
        bus_read(IDX_STATUS_TWO, 8'h20);
        bus_read(IDX_STATUS_ONE, 8'h00);
        bus_write(IDX_STATUS_TWO, 8'h00, 4'h0);
        idle(1);
        @(negedge sys_clk);
        check({7'h00, gpio_out}, 8'h01);
        bus_write(IDX_STATUS_TWO, 8'h00, 4'h1);
        idle(1);
        @(negedge sys_clk);
        check({7'h00, gpio_out}, 8'h00);
        // Shutdown timer: limit 3 steps of 2 cycles
        bus_write(IDX_TIMER_LIMIT, 8'h03, 4'h1);
        bus_write(IDX_PIN_CTRL, 8'h02, 4'h1);
        idle(1);
        @(negedge sys_clk);
        check({7'h00, gpio_oe}, 8'h00);
        bus_read(IDX_TIMER_LIMIT, 8'h03);
        bus_read(IDX_PIN_CTRL, 8'h02);
        bus_read(IDX_STATUS_TWO, 8'h00);
        pulse(6);
        idle(6);
        bus_read(IDX_STATUS_TWO, 8'h00);
        pulse(6);
        idle(4);
        pulse(5);
        idle(6);
        bus_read(IDX_STATUS_ONE, 8'h80);
        bus_read(IDX_STATUS_TWO, 8'h20);
        // Over level still stands at the first clearing edge
        bus_read(IDX_STATUS_TWO, 8'h20);
        bus_read(IDX_STATUS_TWO, 8'h00);
        bus_write(IDX_PIN_CTRL, 8'h03, 4'h1);
        bus_read(IDX_PIN_CTRL, 8'h00);
        idle(3);
        if (notes.size() != 0) begin
            failures++;
            $display("MISMATCH at %0t: reads left unanswered", $time);
        end
        complete_run();
    end
endmodule
